/* verilog/oss_top.sv */
// Operation
// - answer only target address 0x39
// - command byte sets pointer, data writes follow
// - repeated start read returns from pointer
// - plain read uses current pointer, advanced per data byte
// - reset enters sleep, oscillator stopped
// - addressed transaction wakes serial core temporarily
// - power bit starts oscillator, idle until engine
// - first sleep exit with engines adds pause
// - order idle prox gesture wait colour sleep
// - each state skipped by own enable
// - wait 2.78 ms steps up to 8.54 s
// - cycle end returns idle or sleep
// - sleep after interrupt keeps registers unchanged
// - interrupt clear or bit clear ends sleep
// - only prox and gesture pulse the led
// - config two bit7 enables saturation interrupt
// - config three bit5 enables gain compensation
// - config three bits3..0 mask photodiodes
// - 0xE7 clears all, 0xE5 clears prox; here both clear only pint and pgsat, avalid is never cleared
// - clears act on address-only transaction
// - reading prox result clears valid flag
// - persistence counts consecutive out-of-threshold results
// - prox flag readable, enable gates pin
`default_nettype none
module oss_top
  import oss_pkg::*;
#(
  parameter int WAIT_STEP  = WAIT_STEP_CYC,
  parameter int EXIT_PAUSE = EXIT_SLEEP_CYC,
  parameter int PROX_CONV  = PROX_CONV_CYC,
  parameter int ALS_CONV   = ALS_CONV_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // photodiode front end
  input  wire logic [7:0] pd_up,
  input  wire logic [7:0] pd_down,
  input  wire logic [7:0] pd_left,
  input  wire logic [7:0] pd_right,
  input  wire logic       prox_saturated,
  // outputs to the chip
  output logic            led_drive_output,
  output logic            int_n,
  output logic            osc_running,
  output logic            serial_awake
);
  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  // two flops per pin, then a history copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] enables_q, wait_time_value_q, lo_thr_q, hi_thr_q, persist_q, config_one_q;
  logic [7:0] pulse_setup_q, gain_drive_q, config_two_q, offset_ur_q, offset_dl_q;
  logic [7:0] config_three_q, config_four_q, prox_result_q;
  logic       pvalid_q, pint_q, pgsat_q, avalid_q;
  logic       wr_stb, rd_stb, clr_prox, clr_all;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic       sleep_after_irq, gesture_mode_flag, int_pending;
  assign sleep_after_irq   = config_one_q[6];
  assign gesture_mode_flag = config_four_q[CF4_GEST_MODE];

  // read mux, reserved and unmapped read zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      OFS_ENABLES:      reg_read = enables_q;
      OFS_WAIT_TIME:    reg_read = wait_time_value_q;
      OFS_PROX_LO_THR:  reg_read = lo_thr_q;
      OFS_PROX_HI_THR:  reg_read = hi_thr_q;
      OFS_PERSIST:      reg_read = persist_q;
      OFS_CONFIG_ONE:   reg_read = config_one_q;
      OFS_PULSE_SETUP:  reg_read = pulse_setup_q;
      OFS_GAIN_DRIVE:   reg_read = gain_drive_q;
      OFS_CONFIG_TWO:   reg_read = config_two_q;
      OFS_EVENT_FLAGS:  reg_read = {1'b0, pgsat_q, pint_q, 3'b000, pvalid_q, avalid_q};
      OFS_PROX_RESULT:  reg_read = prox_result_q;
      OFS_OFFSET_UR:    reg_read = offset_ur_q;
      OFS_OFFSET_DL:    reg_read = offset_dl_q;
      OFS_CONFIG_THREE: reg_read = config_three_q;
      OFS_CONFIG_FOUR:  reg_read = config_four_q;
      default:          reg_read = 8'h00;
    endcase
  endfunction
  assign rd_data = reg_read(rd_addr);

  // writable registers, untouched by sequencer sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_q <= REG_RESET;  wait_time_value_q <= REG_RESET; lo_thr_q <= REG_RESET;
      hi_thr_q <= REG_RESET;   persist_q <= REG_RESET;         config_one_q <= REG_RESET;
      pulse_setup_q <= REG_RESET; gain_drive_q <= REG_RESET;   config_two_q <= REG_RESET;
      offset_ur_q <= REG_RESET; offset_dl_q <= REG_RESET;      config_three_q <= REG_RESET;
      config_four_q <= REG_RESET;
    end else if (wr_stb) begin
      unique case (wr_addr)
        OFS_ENABLES:      enables_q <= wr_data;
        OFS_WAIT_TIME:    wait_time_value_q <= wr_data;
        OFS_PROX_LO_THR:  lo_thr_q <= wr_data;
        OFS_PROX_HI_THR:  hi_thr_q <= wr_data;
        OFS_PERSIST:      persist_q <= wr_data;
        OFS_CONFIG_ONE:   config_one_q <= wr_data;
        OFS_PULSE_SETUP:  pulse_setup_q <= wr_data;
        OFS_GAIN_DRIVE:   gain_drive_q <= wr_data;
        OFS_CONFIG_TWO:   config_two_q <= wr_data;
        OFS_OFFSET_UR:    offset_ur_q <= wr_data;
        OFS_OFFSET_DL:    offset_dl_q <= wr_data;
        OFS_CONFIG_THREE: config_three_q <= wr_data;
        OFS_CONFIG_FOUR:  config_four_q <= wr_data;
        default:          ;
      endcase
    end
  end

  // ****************************************
  // serial target
  // ****************************************
  oss_i2c_e   i_state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic       ack_q, cmd_only_q;
  logic       rd_stb_q, wr_stb_q, clr_prox_q, clr_all_q;
  logic [7:0] wr_addr_q, wr_data_q;
  assign wr_stb  = wr_stb_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign rd_stb  = rd_stb_q;
  assign rd_addr = ptr_q;
  assign clr_prox = clr_prox_q;
  assign clr_all  = clr_all_q;

  // byte engine: shift on rise, drive on fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i_state_q <= I_IDLE; bit_cnt_q <= 4'h0; shift_q <= 8'h00; tx_q <= 8'h00;
      ptr_q <= 8'h00; ack_q <= 1'b0; cmd_only_q <= 1'b0; sda_oe <= 1'b0;
      wr_stb_q <= 1'b0; rd_stb_q <= 1'b0; wr_addr_q <= 8'h00; wr_data_q <= 8'h00;
      clr_prox_q <= 1'b0; clr_all_q <= 1'b0;
    end else begin
      wr_stb_q   <= 1'b0;
      rd_stb_q   <= 1'b0;
      clr_prox_q <= 1'b0;
      clr_all_q  <= 1'b0;
      if (bus_start || bus_stop) begin
        // command with no data byte: address access
        if (cmd_only_q) begin
          clr_prox_q <= (ptr_q == OFS_PROX_CLR);
          clr_all_q  <= (ptr_q == OFS_ALL_CLR);
        end
        cmd_only_q <= 1'b0;
        ack_q      <= 1'b0;
        sda_oe     <= 1'b0;
        bit_cnt_q  <= 4'h0;
        i_state_q  <= bus_start ? I_ADDR : I_IDLE;
      end else if (scl_rise) begin
        if (i_state_q == I_RDATA) begin
          // master ack slot after a sent byte
          if (bit_cnt_q == 4'h9) begin
            if (sda_s_q) i_state_q <= I_SKIP;
            else ack_q <= 1'b1;
          end
        end else if (!ack_q && i_state_q != I_IDLE && i_state_q != I_SKIP) begin
          shift_q   <= {shift_q[6:0], sda_s_q};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q     <= 1'b0;
          sda_oe    <= 1'b0;
          bit_cnt_q <= 4'h0;
          if (i_state_q == I_RDATA) begin
            // load next byte from pointer
            tx_q      <= {rd_data[6:0], 1'b0};
            sda_oe    <= ~rd_data[7];
            bit_cnt_q <= 4'h1;
            rd_stb_q  <= 1'b1;
          end
        end else if (i_state_q == I_RDATA) begin
          if (bit_cnt_q == 4'h1) ptr_q <= ptr_q + 8'h01;
          if (bit_cnt_q < 4'h8) begin
            sda_oe    <= ~tx_q[7];
            tx_q      <= {tx_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else begin
            sda_oe    <= 1'b0;
            bit_cnt_q <= 4'h9;
          end
        end else if (bit_cnt_q == 4'h8) begin
          unique case (i_state_q)
            I_ADDR: begin
              if (shift_q[7:1] == TARGET_ADDR) begin
                ack_q     <= 1'b1;
                sda_oe    <= 1'b1;
                i_state_q <= shift_q[0] ? I_RDATA : I_CMD;
              end else begin
                i_state_q <= I_SKIP;
              end
            end
            I_CMD: begin
              ptr_q      <= shift_q;
              cmd_only_q <= 1'b1;
              ack_q      <= 1'b1;
              sda_oe     <= 1'b1;
              i_state_q  <= I_WDATA;
            end
            I_WDATA: begin
              wr_stb_q   <= 1'b1;
              wr_addr_q  <= ptr_q;
              wr_data_q  <= shift_q;
              ptr_q      <= ptr_q + 8'h01;
              cmd_only_q <= 1'b0;
              ack_q      <= 1'b1;
              sda_oe     <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end
  assign sda_o = 1'b0; // open drain, only pulls low

  // ****************************************
  // event flags and interrupt pin
  // ****************************************
  oss_seq_e   seq_q;
  logic       prox_done, als_done, prox_out, prox_fire;
  logic [7:0] prox_new;
  logic [3:0] persistence_filters_cnt_q;
  assign int_pending = (pint_q & enables_q[EN_PIEN])
                     | (pgsat_q & config_two_q[CF2_PSIEN]);
  assign prox_out  = (prox_new < lo_thr_q) || (prox_new > hi_thr_q);
  assign prox_fire = prox_out && (({1'b0, persistence_filters_cnt_q} + 5'h01) >= {1'b0, persist_q[7:4]});

  // persistence count, reset by in-threshold result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) persistence_filters_cnt_q <= 4'h0;
    else if (prox_done) begin
      if (!prox_out) persistence_filters_cnt_q <= 4'h0;
      else if (persistence_filters_cnt_q != 4'hf) persistence_filters_cnt_q <= persistence_filters_cnt_q + 4'h1;
    end
  end

  // sticky flags: set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pvalid_q <= 1'b0; pint_q <= 1'b0; pgsat_q <= 1'b0; avalid_q <= 1'b0;
      prox_result_q <= 8'h00;
    end else begin
      if (prox_done) prox_result_q <= prox_new;
      if (prox_done) pvalid_q <= 1'b1;
      else if (rd_stb && rd_addr == OFS_PROX_RESULT) pvalid_q <= 1'b0;
      if (prox_done && prox_fire) pint_q <= 1'b1;
      else if (clr_prox || clr_all) pint_q <= 1'b0;
      if (prox_done && prox_saturated) pgsat_q <= 1'b1;
      else if (clr_prox || clr_all) pgsat_q <= 1'b0;
      if (als_done) avalid_q <= 1'b1;
    end
  end

  // active low pin held while anything enabled pends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) int_n <= 1'b1;
    else int_n <= ~int_pending;
  end

  // ****************************************
  // proximity result from masked photodiodes
  // ****************************************
  logic [9:0] pd_sum;
  logic [8:0] pd_cmp;
  always_comb begin
    pd_sum = {2'b00, config_three_q[CF3_MSK_U] ? 8'h00 : pd_up}
           + {2'b00, config_three_q[CF3_MSK_D] ? 8'h00 : pd_down}
           + {2'b00, config_three_q[CF3_MSK_L] ? 8'h00 : pd_left}
           + {2'b00, config_three_q[CF3_MSK_R] ? 8'h00 : pd_right};
    pd_cmp = {1'b0, pd_sum[9:2]};
    if (config_three_q[CF3_PCMP] && (config_three_q[3:0] != 4'h0)) pd_cmp = {pd_sum[9:2], 1'b0};
    prox_new = pd_cmp[8] ? 8'hff : pd_cmp[7:0];
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic [31:0] timer_q, pulse_tmr_q;
  logic [6:0]  pulses_q;
  logic        exited_q, state_done, led_q;
  logic [11:0] wait_steps;
  logic [3:0]  stage_en;
  assign stage_en = {enables_q[EN_AEN], enables_q[EN_WEN],
                     enables_q[EN_GEST] & gesture_mode_flag, enables_q[EN_PEN]};
  assign wait_steps = (12'h100 - {4'h0, wait_time_value_q})
                    * (config_one_q[CF1_WLONG] ? {8'h00, WLONG_MULT} : 12'h001);

  // first enabled stage at or after position
  function automatic oss_seq_e next_stage(input logic [3:0] en, input logic [2:0] from);
    next_stage = S_IDLE;
    if      (from <= 3'd0 && en[0]) next_stage = S_PROX;
    else if (from <= 3'd1 && en[1]) next_stage = S_GEST;
    else if (from <= 3'd2 && en[2]) next_stage = S_WAIT;
    else if (from <= 3'd3 && en[3]) next_stage = S_ALS;
  endfunction

  // done when timer spent, and for prox and gesture also the pulse train finished
  always_comb begin
    unique case (seq_q)
      S_EXIT:  state_done = (timer_q >= EXIT_PAUSE - 1);
      S_PROX:  state_done = (pulses_q == 7'h00) && (timer_q >= PROX_CONV - 1);
      S_GEST:  state_done = (pulses_q == 7'h00) && (timer_q >= PROX_CONV - 1);
      S_WAIT:  state_done = (timer_q >= {20'h0_0000, wait_steps} * WAIT_STEP - 1);
      S_ALS:   state_done = (timer_q >= ALS_CONV - 1);
      default: state_done = 1'b0;
    endcase
  end
  assign prox_done = (seq_q == S_PROX) && state_done;
  assign als_done  = (seq_q == S_ALS) && state_done;

  // flow between states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= S_SLEEP;
      exited_q <= 1'b0;
    end else if (!enables_q[EN_PON] && seq_q != S_SLEEP) begin
      seq_q <= S_SLEEP;
      exited_q <= 1'b0;
    end else begin
      unique case (seq_q)
        S_SLEEP: if (enables_q[EN_PON] && !(sleep_after_irq && int_pending)) begin
          if (!exited_q && (enables_q[EN_PEN] | enables_q[EN_GEST] | enables_q[EN_AEN])) begin
            seq_q <= S_EXIT;
            exited_q <= 1'b1;
          end else begin
            seq_q <= S_IDLE;
          end
        end
        S_IDLE:  seq_q <= (sleep_after_irq && int_pending) ? S_SLEEP : next_stage(stage_en, 3'd0);
        S_EXIT:  if (state_done) seq_q <= next_stage(stage_en, 3'd0);
        S_PROX:  if (state_done) seq_q <= next_stage(stage_en, 3'd1);
        S_GEST:  if (state_done) seq_q <= next_stage(stage_en, 3'd2);
        S_WAIT:  if (state_done) seq_q <= next_stage(stage_en, 3'd3);
        S_ALS:   if (state_done) seq_q <= (sleep_after_irq && int_pending) ? S_SLEEP : S_IDLE;
      endcase
    end
  end

  // state timer and led pulse train
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 32'h0000_0000; pulse_tmr_q <= 32'h0000_0000; pulses_q <= 7'h00;
    end else if (state_done || seq_q == S_IDLE || seq_q == S_SLEEP) begin
      timer_q     <= 32'h0000_0000;
      pulse_tmr_q <= 32'h0000_0000;
      pulses_q    <= {1'b0, pulse_setup_q[5:0]} + 7'h01;
    end else if (pulses_q != 7'h00 && (seq_q == S_PROX || seq_q == S_GEST)) begin
      if (pulse_tmr_q >= PULSE_PER_CYC - 1) begin
        pulse_tmr_q <= 32'h0000_0000;
        pulses_q    <= pulses_q - 7'h01;
      end else begin
        pulse_tmr_q <= pulse_tmr_q + 32'h0000_0001;
      end
    end else begin
      timer_q <= timer_q + 32'h0000_0001;
    end
  end

  // led only from prox and gesture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) led_q <= 1'b0;
    else led_q <= (seq_q == S_PROX || seq_q == S_GEST) && (pulses_q != 7'h00)
                  && (pulse_tmr_q < PULSE_ON_CYC);
  end
  assign led_drive_output = led_q;

  // oscillator runs outside sleep or while the serial engine is neither idle nor skipping, address phase included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_running  <= 1'b0;
      serial_awake <= 1'b0;
    end else begin
      serial_awake <= (i_state_q != I_IDLE) && (i_state_q != I_SKIP) && (i_state_q != I_ADDR);
      osc_running  <= (seq_q != S_SLEEP) || ((i_state_q != I_IDLE) && (i_state_q != I_SKIP));
    end
  end
endmodule
`default_nettype wire

/* verilog/oss_pkg.sv */
`default_nettype none
package oss_pkg;
  // ****************************************
  // bus identity and register offsets
  // ****************************************
  localparam logic [6:0] TARGET_ADDR      = 7'h39;
  localparam logic [7:0] OFS_ENABLES      = 8'h80;
  localparam logic [7:0] OFS_WAIT_TIME    = 8'h83;
  localparam logic [7:0] OFS_PROX_LO_THR  = 8'h89;
  localparam logic [7:0] OFS_PROX_HI_THR  = 8'h8b;
  localparam logic [7:0] OFS_PERSIST      = 8'h8c;
  localparam logic [7:0] OFS_CONFIG_ONE   = 8'h8d;
  localparam logic [7:0] OFS_PULSE_SETUP  = 8'h8e;
  localparam logic [7:0] OFS_GAIN_DRIVE   = 8'h8f;
  localparam logic [7:0] OFS_CONFIG_TWO   = 8'h90;
  localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h93;
  localparam logic [7:0] OFS_PROX_RESULT  = 8'h9c;
  localparam logic [7:0] OFS_OFFSET_UR    = 8'h9d;
  localparam logic [7:0] OFS_OFFSET_DL    = 8'h9e;
  localparam logic [7:0] OFS_CONFIG_THREE = 8'h9f;
  localparam logic [7:0] OFS_CONFIG_FOUR  = 8'hab;
  localparam logic [7:0] OFS_PROX_CLR     = 8'he5;
  localparam logic [7:0] OFS_ALL_CLR      = 8'he7;
  // ****************************************
  // field positions
  // ****************************************
  localparam int EN_PON   = 0;
  localparam int EN_AEN   = 1;
  localparam int EN_PEN   = 2;
  localparam int EN_WEN   = 3;
  localparam int EN_PIEN  = 5;
  localparam int EN_GEST  = 6;
  localparam int CF1_WLONG = 1;
  localparam int CF2_PSIEN = 7;
  localparam int CF3_PCMP  = 5;
  localparam int CF3_MSK_U = 3;
  localparam int CF3_MSK_D = 2;
  localparam int CF3_MSK_L = 1;
  localparam int CF3_MSK_R = 0;
  localparam int CF4_GEST_MODE = 0;
  localparam int ST_PGSAT  = 6;
  localparam int ST_PINT   = 5;
  localparam int ST_PVALID = 1;
  localparam int ST_AVALID = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] WLONG_MULT = 4'hc;
  // ****************************************
  // timing, times in ns, counts at clk rate
  // ****************************************
  localparam int CLK_MHZ         = 100;
  localparam int WAIT_STEP_NS    = 2_780_000;
  localparam int WAIT_STEP_CYC   = WAIT_STEP_NS * CLK_MHZ / 1000;
  localparam int EXIT_SLEEP_NS   = 5_000_000;
  localparam int EXIT_SLEEP_CYC  = EXIT_SLEEP_NS * CLK_MHZ / 1000;
  localparam int PROX_CONV_NS    = 796_600;
  localparam int PROX_CONV_CYC   = PROX_CONV_NS * CLK_MHZ / 1000;
  localparam int ALS_CONV_NS     = 1_000_000;
  localparam int ALS_CONV_CYC    = ALS_CONV_NS * CLK_MHZ / 1000;
  localparam int PULSE_ON_NS     = 5_400;
  localparam int PULSE_ON_CYC    = PULSE_ON_NS * CLK_MHZ / 1000;
  localparam int PULSE_PER_NS    = 28_600;
  localparam int PULSE_PER_CYC   = PULSE_PER_NS * CLK_MHZ / 1000;
  // sequencer and serial states
  typedef enum logic [2:0] {S_SLEEP, S_IDLE, S_EXIT, S_PROX, S_GEST, S_WAIT, S_ALS} oss_seq_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CMD, I_WDATA, I_RDATA, I_SKIP} oss_i2c_e;
endpackage
`default_nettype wire

/* verification/oss_top_asserts.sv */
`default_nettype none
// ****************************************
// port checker for the sensor core
// ****************************************
module oss_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // chip outputs
  input wire logic led_drive_output,
  input wire logic int_n,
  input wire logic osc_running,
  input wire logic serial_awake
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] quiet_q;
  logic [15:0] led_on_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since a bus pin moved, cycles of led on time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q  <= 16'h0000;
      led_on_q <= 16'h0000;
    end else begin
      quiet_q  <= ($changed(scl_i) || $changed(sda_i)) ? 16'h0000 : quiet_q + 16'h0001;
      led_on_q <= led_drive_output ? led_on_q + 16'h0001 : 16'h0000;
    end
  end
  property p_sda_o_zero; sda_o == 1'b0; endproperty
  a_sda_o_zero: assert property (p_sda_o_zero) else $error("sda_o not low");
  property p_oe_awake; sda_oe |=> serial_awake; endproperty
  a_oe_awake: assert property (p_oe_awake) else $error("sda pulled while not addressed");
  property p_awake_osc; serial_awake |-> osc_running; endproperty
  a_awake_osc: assert property (p_awake_osc) else $error("serial core awake without oscillator");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda drive moved while scl high");
  property p_led_osc; led_drive_output |-> osc_running; endproperty
  a_led_osc: assert property (p_led_osc) else $error("led on while asleep");
  property p_led_width; $fell(led_drive_output) |-> led_on_q == 16'h021c; endproperty
  a_led_width: assert property (p_led_width) else $error("led pulse width wrong");
  property p_int_rise_bus; $rose(int_n) |-> quiet_q < 16'h0014; endproperty
  a_int_rise_bus: assert property (p_int_rise_bus) else $error("interrupt released without host access");
  property p_osc_rise_bus; $rose(osc_running) |-> quiet_q < 16'h0014; endproperty
  a_osc_rise_bus: assert property (p_osc_rise_bus) else $error("woke without bus activity");
endmodule
bind oss_top oss_top_asserts u_oss_top_asserts (.clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe,
  .led_drive_output, .int_n, .osc_running, .serial_awake);
`default_nettype wire

/* verification/oss_host_model.sv */
`default_nettype none
// ****************************************
// host bus controller model
// ****************************************
module oss_host_model (
  // device side pins
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_low;
  // pulled-up wire, low when either side pulls
  assign sda = ~(drv_low | sda_oe);
  // bus idles released, clock high
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end
  // start or repeated start, clock left low
  task automatic start();
    if (!scl) begin
      drv_low = 1'b0;
      #31.25 scl = 1'b1;
      #31.25;
    end
    drv_low = 1'b1;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // stop, then bus free
  task automatic stop();
    drv_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 drv_low = 1'b0;
    #62.5;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ackb, output logic [7:0] rx, output logic ak);
    logic [8:0] sh;
    sh = {tx, ackb};
    for (int i = 8; i >= 0; i--) begin
      drv_low = ~sh[i];
      #31.25 scl = 1'b1;
      #50 sh[i] = sda;
      #12.5 scl = 1'b0;
      #31.25;
    end
    rx = sh[8:1];
    ak = sh[0];
  endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`default_nettype none
module tb import oss_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, scl, sda, sda_o, sda_oe, prox_saturated, led_seen, led_q, ak;
  logic       led_drive_output, int_n, osc_running, serial_awake;
  logic [7:0] pd_up, pd_down, pd_left, pd_right, rx;
  int         failures, num_checks, led_cnt, led_per, p1;
  logic [7:0] rw_ofs [9] = '{OFS_PROX_LO_THR, OFS_PROX_HI_THR, OFS_PERSIST, OFS_PULSE_SETUP,
                             OFS_GAIN_DRIVE, OFS_CONFIG_TWO, OFS_OFFSET_UR, OFS_OFFSET_DL, OFS_CONFIG_THREE};
  oss_top #(.WAIT_STEP(10), .EXIT_PAUSE(8), .PROX_CONV(20), .ALS_CONV(16)) u_oss_top (.clk, .rst_n,
    .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .pd_up, .pd_down, .pd_left, .pd_right, .prox_saturated,
    .led_drive_output, .int_n, .osc_running, .serial_awake);
  oss_host_model u_oss_host_model (.sda_oe, .scl, .sda);
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // led rise to rise period and seen flag
  always @(posedge clk) begin
    led_q <= led_drive_output;
    led_cnt <= led_cnt + 1;
    if (led_drive_output && !led_q) begin
      led_per <= led_cnt;
      led_cnt <= 1;
      led_seen <= 1'b1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic endt(input int n);
    $display("test %0d done", n);
  endtask
  // bounded wait for led (which=1) or interrupt pin level
  task automatic wait_lvl(input logic which, input logic lvl);
    int n;
    n = 0;
    while ((which ? led_drive_output : int_n) !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 20000) begin
        failures++;
        complete_run();
      end
    end
  endtask
  // one byte to the device, acknowledge expected
  task automatic bx(input logic [7:0] tx);
    logic [7:0] r;
    logic       a;
    u_oss_host_model.byte_io(tx, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
  endtask
  task automatic head(input logic [7:0] ofs);
    u_oss_host_model.start();
    bx({TARGET_ADDR, 1'b0});
    bx(ofs);
  endtask
  task automatic touch(input logic [7:0] ofs);
    head(ofs);
    u_oss_host_model.stop();
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    head(ofs);
    bx(val);
    u_oss_host_model.stop();
  endtask
  // plain read when plain is set, combined read otherwise
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input logic [7:0] msk = 8'hff,
                    input logic plain = 1'b0);
    if (!plain) head(ofs);
    u_oss_host_model.start();
    bx({TARGET_ADDR, 1'b1});
    u_oss_host_model.byte_io(8'hff, 1'b1, rx, ak);
    u_oss_host_model.stop();
    chk(rx & msk, exp);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    prox_saturated = 1'b0;
    led_seen = 1'b0;
    pd_up = 8'h80;
    pd_down = 8'h40;
    pd_left = 8'h20;
    pd_right = 8'h10;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({6'h00, osc_running, int_n}, 8'h01);
    u_oss_host_model.start();
    u_oss_host_model.byte_io({7'h38, 1'b0}, 1'b1, rx, ak);
    chk({7'h00, ak}, 8'h01);
    u_oss_host_model.stop();
    head(OFS_OFFSET_UR);
    chk({6'h00, serial_awake, osc_running}, 8'h03);
    u_oss_host_model.stop();
    repeat (20) @(posedge clk);
    chk({7'h00, osc_running}, 8'h00);
    endt(1);
    foreach (rw_ofs[i]) begin
      rd(rw_ofs[i], 8'h00);
      wr(rw_ofs[i], rw_ofs[i] ^ 8'ha5);
      rd(rw_ofs[i], rw_ofs[i] ^ 8'ha5);
      touch(rw_ofs[i]);
      rd(8'h00, rw_ofs[i] ^ 8'ha5, 8'hff, 1'b1);
      wr(rw_ofs[i], 8'h00);
    end
    wr(OFS_EVENT_FLAGS, 8'hff);
    rd(OFS_EVENT_FLAGS, 8'h00);
    rd(8'ha0, 8'h00);
    endt(2);
    wr(OFS_PROX_LO_THR, 8'h10);
    wr(OFS_PROX_HI_THR, 8'h20);
    wr(OFS_CONFIG_THREE, 8'h28);
    wr(OFS_CONFIG_ONE, 8'h40);
    wr(OFS_ENABLES, 8'h25);
    wait_lvl(1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk({6'h00, led_seen, osc_running}, 8'h02);
    rd(OFS_ENABLES, 8'h25);
    rd(OFS_EVENT_FLAGS, 8'h22);
    rd(OFS_PROX_RESULT, 8'h38);
    rd(OFS_EVENT_FLAGS, 8'h20);
    touch(OFS_PROX_CLR);
    repeat (10) @(posedge clk);
    chk({6'h00, osc_running, int_n}, 8'h03);
    wait_lvl(1'b0, 1'b0);
    wr(OFS_CONFIG_ONE, 8'h00);
    repeat (10) @(posedge clk);
    chk({7'h00, osc_running}, 8'h01);
    wr(OFS_ENABLES, 8'h05);
    repeat (10) @(posedge clk);
    chk({7'h00, int_n}, 8'h01);
    rd(OFS_EVENT_FLAGS, 8'h22);
    endt(3);
    @(posedge clk);
    #1 prox_saturated = 1'b1;
    wr(OFS_CONFIG_TWO, 8'h80);
    wait_lvl(1'b0, 1'b0);
    @(posedge clk);
    #1 prox_saturated = 1'b0;
    touch(OFS_ALL_CLR);
    repeat (4000) @(posedge clk);
    chk({7'h00, int_n}, 8'h01);
    wr(OFS_WAIT_TIME, 8'hff);
    wr(OFS_ENABLES, 8'h0d);
    repeat (8000) @(posedge clk);
    p1 = led_per;
    wr(OFS_CONFIG_ONE, 8'h02);
    repeat (8000) @(posedge clk);
    chk(8'(led_per - p1), 8'h6e);
    wait_lvl(1'b1, 1'b1);
    wait_lvl(1'b1, 1'b0);
    wr(OFS_ENABLES, 8'h03);
    led_seen = 1'b0;
    repeat (4000) @(posedge clk);
    chk({7'h00, led_seen}, 8'h00);
    rd(OFS_EVENT_FLAGS, 8'h01, 8'h01);
    endt(4);
    complete_run();
  end
endmodule
`default_nettype wire
